// ### rtl/pwc_top.sv
// Chosen here: the register offsets and register access over AHB-Lite.
`timescale 1ns/1ps

// Summary of operation
// - Source internal or external, internal by default; shape and rate used internally.
// - Reset leaves the sinusoidal shape; shape read returns one of seven codes.
// - Half-duty 50% duty, rising 100%, symmetric 50%, falling 0% symmetry.
// - Stored arbitrary shape is decimated down to at most 4K points; above 126976 points the step is 0.
// - Modulating rate accepted only 2 mHz to 20 kHz, resets to 10 Hz.
// - Width deviation in time, default 10 us, limited 0 to 1000 s.
// - Width deviation never above the carrier pulse width.
// - Width deviation limited by minimum width on both sides of the pulse.
// - Minimum width 20 ns, 200 ns, 2 us or 20 us by period band.
// - Width deviation limited by 1.6 times edge time on both sides.
// - External level scales deviation linearly, full scale gives set deviation, signed.
// - Held width keeps width deviation, held duty keeps duty deviation over period.
// - Under duty hold a width deviation write converts to duty deviation.
// - Under width hold a duty deviation write converts to width deviation.
// - Duty deviation in percent of period, default 1 percent.
// - Duty deviation never above the carrier duty cycle.
// - Duty deviation limited by 100 times minimum width over period, both sides.
// - Duty deviation limited by 160 times edge time over period, both sides.
// - Reset with modulation off; enable reads 0 off and 1 on in bit 0 of the control word read.
// - Enabling clears any other modulation mode.
// - Enabling clears sweep and burst.
// - Enable allowed only while the carrier is the pulse function.
module pwc_top (
	// Clock and reset
	input wire logic clock_i,
	input wire logic rst_b_i,
	// AHB-Lite slave
	input wire logic hsel_i,
	input wire logic [31:0] haddr_i,
	input wire logic [1:0] htrans_i,
	input wire logic hwrite_i,
	input wire logic [2:0] hsize_i,
	input wire logic [31:0] hwdata_i,
	input wire logic hready_i,
	output logic [31:0] hrdata_o,
	output logic hreadyout_o,
	output logic hresp_o,
	// External modulation level, full positive scale is +5V
	input wire logic signed [15:0] ext_level_i,
	// Modulator settings
	output pwc_pkg::pwc_ctrl_type mod_ctrl_o,
	output logic [2:0] shape_o,
	output logic [6:0] shape_sym_o,
	output logic [31:0] mod_freq_o,
	output logic [4:0] decim_step_o,
	output logic signed [40:0] eff_wdev_o,
	output logic signed [14:0] eff_ddev_o
);

	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	function automatic pwc_pkg::pwc_time_type sub0(input pwc_pkg::pwc_time_type a,
			input pwc_pkg::pwc_time_type b);
		sub0 = (a > b) ? a - b : 40'h0;
	endfunction

	function automatic pwc_pkg::pwc_time_type min2(input pwc_pkg::pwc_time_type a,
			input pwc_pkg::pwc_time_type b);
		min2 = (a < b) ? a : b;
	endfunction

	// Time to hundredths of a percent of period
	function automatic pwc_pkg::pwc_pct_type to_pct(input pwc_pkg::pwc_time_type t,
			input pwc_pkg::pwc_time_type p);
		logic [63:0] q;
		q = ({24'h0, t} * 64'(pwc_pkg::FULL_PCT)) / {24'h0, p};
		to_pct = (q > 64'(pwc_pkg::FULL_PCT)) ? pwc_pkg::FULL_PCT : q[13:0];
	endfunction

	// Hundredths of a percent to time
	function automatic pwc_pkg::pwc_time_type to_time(input pwc_pkg::pwc_pct_type d,
			input pwc_pkg::pwc_time_type p);
		logic [63:0] q;
		q = ({50'h0, d} * {24'h0, p}) / 64'(pwc_pkg::FULL_PCT);
		to_time = q[39:0];
	endfunction

	// ----------------------------------------
	// Bus front end
	// ----------------------------------------
	pwc_pkg::pwc_bus_state_type st_q, st_d;
	logic [7:0] addr_q;
	logic [7:0] stage_q;
	logic [7:0] rd_hi_q;
	logic [31:0] rdata;
	logic [7:0] rd_hi_d;
	wire acc = hsel_i & htrans_i[1] & hready_i;
	wire commit = (st_q == pwc_pkg::BUS_WR);
	wire rd_load = (st_q == pwc_pkg::BUS_RD);
	wire [39:0] wdata40 = {stage_q, hwdata_i};

	// Read takes one wait state so the data leaves a flip-flop
	always_comb begin
		case (st_q)
			pwc_pkg::BUS_RD: st_d = pwc_pkg::BUS_RD_DONE;
			pwc_pkg::BUS_IDLE, pwc_pkg::BUS_WR, pwc_pkg::BUS_RD_DONE: begin
				if (acc) begin
					st_d = hwrite_i ? pwc_pkg::BUS_WR : pwc_pkg::BUS_RD;
				end else begin
					st_d = pwc_pkg::BUS_IDLE;
				end
			end
			default: st_d = pwc_pkg::BUS_IDLE;
		endcase
	end

	// Bus state and data phase flops
	always_ff @(posedge clock_i) begin
		if (!rst_b_i) begin
			st_q <= pwc_pkg::BUS_IDLE;
			addr_q <= 8'h00;
			hreadyout_o <= 1'b1;
			hrdata_o <= 32'h0000_0000;
			hresp_o <= 1'b0;
			rd_hi_q <= 8'h00;
		end else begin
			st_q <= st_d;
			hreadyout_o <= (st_d != pwc_pkg::BUS_RD);
			hresp_o <= 1'b0;
			if (acc) begin
				addr_q <= haddr_i[7:0];
			end
			if (rd_load) begin
				hrdata_o <= rdata;
				rd_hi_q <= rd_hi_d;
			end
		end
	end

	// ----------------------------------------
	// Settings
	// ----------------------------------------
	pwc_pkg::pwc_ctrl_type ctrl_q, ctrl_d;
	pwc_pkg::pwc_shape_type shape_q;
	logic [31:0] freq_q;
	pwc_pkg::pwc_time_type wdev_q, period_q, width_q, edge_q;
	pwc_pkg::pwc_pct_type ddev_q;
	logic [16:0] points_q;

	wire wr_ctrl = commit & (addr_q == pwc_pkg::CTRL_OFS);
	wire wr_shape = commit & (addr_q == pwc_pkg::SHAPE_OFS);
	wire wr_freq = commit & (addr_q == pwc_pkg::FREQ_OFS);
	wire wr_wdev = commit & (addr_q == pwc_pkg::WDEV_OFS);
	wire wr_ddev = commit & (addr_q == pwc_pkg::DDEV_OFS);
	wire wr_period = commit & (addr_q == pwc_pkg::PERIOD_OFS) & (wdata40 != 40'h0);
	wire wr_width = commit & (addr_q == pwc_pkg::WIDTH_OFS);
	wire wr_edge = commit & (addr_q == pwc_pkg::EDGE_OFS);
	wire wr_hi = commit & (addr_q == pwc_pkg::HI_OFS);
	wire wr_points = commit & (addr_q == pwc_pkg::POINTS_OFS);

	wire freq_ok = (hwdata_i >= pwc_pkg::FREQ_MIN_MHZ) && (hwdata_i <= pwc_pkg::FREQ_MAX_MHZ);
	// only the seven shape codes are stored
	wire shape_ok = (hwdata_i[2:0] != 3'h7);

	// enable clears rivals, needs pulse carrier
	always_comb begin
		ctrl_d = pwc_pkg::pwc_ctrl_type'(hwdata_i[8:0]);
		if (!ctrl_d.pulse_carrier) begin
			ctrl_d.pwm_en = 1'b0;
		end
		if (ctrl_d.pwm_en) begin
			ctrl_d.other_mod = 3'h0;
			ctrl_d.sweep = 1'b0;
			ctrl_d.burst = 1'b0;
		end
	end

	// ----------------------------------------
	// Deviation limits
	// ----------------------------------------
	// minimum width by period band
	wire [39:0] wmin = (period_q <= pwc_pkg::BAND1_NS) ? pwc_pkg::WMIN1_NS :
		(period_q <= pwc_pkg::BAND2_NS) ? pwc_pkg::WMIN2_NS :
		(period_q <= pwc_pkg::BAND3_NS) ? pwc_pkg::WMIN3_NS : pwc_pkg::WMIN4_NS;
	wire [44:0] edge_x = (45'(edge_q) * 45'(pwc_pkg::EDGE_NUM)) / 45'(pwc_pkg::EDGE_DEN);
	wire [39:0] edge16 = edge_x[39:0];
	wire [39:0] guard = (wmin > edge16) ? wmin : edge16;
	wire [39:0] space = sub0(period_q, width_q);
	// tighter of both sides, never above width
	wire [39:0] lim_w = min2(min2(sub0(width_q, guard), sub0(space, guard)),
		pwc_pkg::WDEV_MAX_NS);
	wire [13:0] duty = to_pct(width_q, period_q);
	// both margins turned into duty terms
	wire [13:0] t_wmin = to_pct(wmin, period_q);
	wire [63:0] t_edge_x = ({24'h0, edge_q} * 64'(pwc_pkg::DUTY_EDGE_K)) / {24'h0, period_q};
	wire [13:0] t_edge = (t_edge_x > 64'(pwc_pkg::FULL_PCT)) ? pwc_pkg::FULL_PCT :
		t_edge_x[13:0];
	wire [13:0] dguard = (t_wmin > t_edge) ? t_wmin : t_edge;
	wire [39:0] lim_d40 = min2(sub0(40'(duty), 40'(dguard)),
		sub0(40'(pwc_pkg::FULL_PCT - duty), 40'(dguard)));
	wire [13:0] lim_d = lim_d40[13:0];
	// written width deviation clamped into range
	wire [39:0] wdev_new = min2(wdata40, lim_w);
	wire [13:0] ddev_new = (hwdata_i > 32'(lim_d)) ? lim_d : hwdata_i[13:0];

	// Settings registers
	always_ff @(posedge clock_i) begin
		if (!rst_b_i) begin
			ctrl_q <= pwc_pkg::CTRL_RST;
			shape_q <= pwc_pkg::SHAPE_SMOOTH;
			freq_q <= pwc_pkg::FREQ_RST_MHZ;
			period_q <= pwc_pkg::PERIOD_RST_NS;
			width_q <= pwc_pkg::WIDTH_RST_NS;
			edge_q <= pwc_pkg::EDGE_RST_NS;
			stage_q <= 8'h00;
			points_q <= pwc_pkg::POINTS_RST;
		end else begin
			if (wr_ctrl) ctrl_q <= ctrl_d;
			if (wr_shape && shape_ok) shape_q <= pwc_pkg::pwc_shape_type'(hwdata_i[2:0]);
			if (wr_freq && freq_ok) freq_q <= hwdata_i;
			if (wr_period) period_q <= wdata40;
			if (wr_width) width_q <= wdata40;
			if (wr_edge) edge_q <= wdata40;
			if (wr_hi) stage_q <= hwdata_i[7:0];
			if (wr_points) points_q <= hwdata_i[16:0];
		end
	end

	// Both deviation forms are kept so a hold switch needs no recompute
	always_ff @(posedge clock_i) begin
		if (!rst_b_i) begin
			wdev_q <= pwc_pkg::WDEV_RST_NS;
			ddev_q <= pwc_pkg::DDEV_RST;
		end else if (wr_wdev) begin
			// width write also yields duty form
			wdev_q <= wdev_new;
			ddev_q <= to_pct(wdev_new, period_q);
		end else if (wr_ddev) begin
			// duty write also yields width form
			ddev_q <= ddev_new;
			wdev_q <= to_time(ddev_new, period_q);
		end else if (wr_period && ctrl_q.hold_duty) begin
			// duty held, width form follows period
			wdev_q <= to_time(ddev_q, wdata40);
		end else if (wr_period) begin
			// width held, duty form follows period
			ddev_q <= to_pct(wdev_q, wdata40);
		end
	end

	// ----------------------------------------
	// Readback
	// ----------------------------------------
	wire [31:0] status = {11'h0, decim_step_o, 2'h0, duty};
	always_comb begin
		rdata = 32'h0000_0000;
		rd_hi_d = rd_hi_q;
		case (addr_q)
			// enable reads back as 0 or 1 in bit 0
			pwc_pkg::CTRL_OFS: rdata = {23'h0, ctrl_q};
			pwc_pkg::SHAPE_OFS: rdata = {29'h0, shape_q};
			pwc_pkg::FREQ_OFS: rdata = freq_q;
			pwc_pkg::WDEV_OFS: {rd_hi_d, rdata} = wdev_q;
			pwc_pkg::DDEV_OFS: rdata = {18'h0, ddev_q};
			pwc_pkg::PERIOD_OFS: {rd_hi_d, rdata} = period_q;
			pwc_pkg::WIDTH_OFS: {rd_hi_d, rdata} = width_q;
			pwc_pkg::EDGE_OFS: {rd_hi_d, rdata} = edge_q;
			pwc_pkg::HI_OFS: rdata = {24'h0, rd_hi_q};
			pwc_pkg::POINTS_OFS: rdata = {15'h0, points_q};
			pwc_pkg::STATUS_OFS: rdata = status;
			default: rdata = 32'h0000_0000;
		endcase
	end

	// ----------------------------------------
	// Modulator outputs
	// ----------------------------------------
	logic [6:0] sym;
	always_comb begin
		case (shape_q)
			pwc_pkg::SHAPE_HALF_DUTY: sym = pwc_pkg::SYM_HALF;
			pwc_pkg::SHAPE_RISING: sym = pwc_pkg::SYM_FULL;
			pwc_pkg::SHAPE_SYMMETRIC: sym = pwc_pkg::SYM_HALF;
			pwc_pkg::SHAPE_FALLING: sym = pwc_pkg::SYM_NONE;
			default: sym = pwc_pkg::SYM_HALF;
		endcase
	end

	// decimation step, rounded up, at least one up to 126976 points, 0 above that
	wire [17:0] pts_sum = 18'(points_q) + 18'(pwc_pkg::PTS_ROUND);
	wire [5:0] step_raw = 6'(pts_sum >> pwc_pkg::PTS_SHIFT);
	wire [4:0] step = (step_raw == 6'h0) ? 5'h01 : step_raw[4:0];

	// signed scaling by the external level
	wire signed [57:0] wprod = $signed({1'b0, wdev_q}) * ext_level_i;
	wire signed [31:0] dprod = $signed({1'b0, ddev_q}) * ext_level_i;
	wire signed [40:0] wscaled = 41'(wprod >>> pwc_pkg::EXT_SHIFT);
	wire signed [14:0] dscaled = 15'(dprod >>> pwc_pkg::EXT_SHIFT);
	// internal source uses the full set deviation
	wire signed [40:0] wsel = ctrl_q.ext_src ? wscaled : $signed({1'b0, wdev_q});
	wire signed [14:0] dsel = ctrl_q.ext_src ? dscaled : $signed({1'b0, ddev_q});

	// Registered outputs, deviation zero while disabled
	always_ff @(posedge clock_i) begin
		if (!rst_b_i) begin
			mod_ctrl_o <= pwc_pkg::CTRL_RST;
			shape_o <= 3'h0;
			shape_sym_o <= 7'h00;
			mod_freq_o <= 32'h0000_0000;
			decim_step_o <= 5'h01;
			eff_wdev_o <= 41'sh0;
			eff_ddev_o <= 15'sh0;
		end else begin
			mod_ctrl_o <= ctrl_q;
			shape_o <= shape_q;
			shape_sym_o <= sym;
			mod_freq_o <= freq_q;
			decim_step_o <= step;
			eff_wdev_o <= ctrl_q.pwm_en ? wsel : 41'sh0;
			eff_ddev_o <= ctrl_q.pwm_en ? dsel : 15'sh0;
		end
	end

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	default clocking cb @(posedge clock_i); endclocking
	default disable iff (!rst_b_i);

	chk_reset_defaults: assert property (
		$rose(rst_b_i) |-> shape_q == pwc_pkg::SHAPE_SMOOTH && !ctrl_q.pwm_en &&
			freq_q == pwc_pkg::FREQ_RST_MHZ && ddev_q == pwc_pkg::DDEV_RST)
		else $error("bad reset defaults");
	chk_freq_range: assert property (
		wr_freq && !freq_ok |=> $stable(freq_q))
		else $error("out of range rate stored");
	chk_wdev_width: assert property (
		wr_wdev |=> wdev_q <= width_q && wdev_q <= lim_w)
		else $error("width deviation above limit");
	chk_ddev_duty: assert property (
		wr_ddev |=> ddev_q <= duty)
		else $error("duty deviation above duty");
	chk_mode_excl: assert property (
		ctrl_q.pwm_en |-> ctrl_q.other_mod == 3'h0 && !ctrl_q.sweep && !ctrl_q.burst)
		else $error("rival mode active with modulation");
	chk_pulse_only: assert property (
		wr_ctrl && !hwdata_i[3] |=> !ctrl_q.pwm_en)
		else $error("enabled without pulse carrier");
	chk_hold_width: assert property (
		wr_period && !ctrl_q.hold_duty |=> $stable(wdev_q) ##1 $stable(wdev_q))
		else $error("held width deviation moved");
	chk_ext_zero: assert property (
		ctrl_q.pwm_en && ctrl_q.ext_src && ext_level_i == 16'sh0 |=> eff_wdev_o == 41'sh0)
		else $error("zero level gave deviation");
	chk_read_wait: assert property (
		acc && !hwrite_i |=> !hreadyout_o ##1 hreadyout_o && hrdata_o == $past(rdata))
		else $error("read timing wrong");

	cov_enable: cover property (wr_ctrl ##1 ctrl_q.pwm_en);
	cov_ext: cover property (ctrl_q.pwm_en && ctrl_q.ext_src && eff_wdev_o < 41'sh0);
	cov_clamp: cover property (wr_wdev && wdata40 > lim_w);

endmodule

// ### rtl/pwc_pkg.sv
package pwc_pkg;

	// ----------------------------------------
	// Register map (byte addresses)
	// ----------------------------------------
	localparam logic [7:0] CTRL_OFS = 8'h00;
	localparam logic [7:0] SHAPE_OFS = 8'h04;
	localparam logic [7:0] FREQ_OFS = 8'h08;
	localparam logic [7:0] WDEV_OFS = 8'h0c;
	localparam logic [7:0] DDEV_OFS = 8'h10;
	localparam logic [7:0] PERIOD_OFS = 8'h14;
	localparam logic [7:0] WIDTH_OFS = 8'h18;
	localparam logic [7:0] EDGE_OFS = 8'h1c;
	localparam logic [7:0] HI_OFS = 8'h20;
	localparam logic [7:0] POINTS_OFS = 8'h24;
	localparam logic [7:0] STATUS_OFS = 8'h28;

	// ----------------------------------------
	// Types
	// ----------------------------------------
	typedef logic [39:0] pwc_time_type;
	typedef logic [13:0] pwc_pct_type;

	// Control word, bit 0 is the enable
	typedef struct packed {
		logic burst;
		logic sweep;
		logic [2:0] other_mod;
		logic pulse_carrier;
		logic hold_duty;
		logic ext_src;
		logic pwm_en;
	} pwc_ctrl_type;

	typedef enum logic [2:0] {
		SHAPE_SMOOTH = 3'h0,
		SHAPE_HALF_DUTY = 3'h1,
		SHAPE_RISING = 3'h2,
		SHAPE_FALLING = 3'h3,
		SHAPE_SYMMETRIC = 3'h4,
		SHAPE_RANDOM = 3'h5,
		SHAPE_USER = 3'h6
	} pwc_shape_type;

	typedef enum logic [1:0] {
		BUS_IDLE = 2'h0,
		BUS_RD = 2'h1,
		BUS_RD_DONE = 2'h3,
		BUS_WR = 2'h2
	} pwc_bus_state_type;

	// ----------------------------------------
	// Reset values and limits
	// ----------------------------------------
	localparam pwc_ctrl_type CTRL_RST = 9'h000;
	localparam logic [31:0] FREQ_MIN_MHZ = 32'h0000_0002;
	localparam logic [31:0] FREQ_MAX_MHZ = 32'h0131_2d00;
	localparam logic [31:0] FREQ_RST_MHZ = 32'h0000_2710;
	localparam pwc_time_type WDEV_RST_NS = 40'h00_0000_2710;
	localparam pwc_time_type WDEV_MAX_NS = 40'he8_d4a5_1000;
	localparam pwc_pct_type DDEV_RST = 14'h0064;
	localparam pwc_pct_type FULL_PCT = 14'h2710;
	localparam pwc_time_type PERIOD_RST_NS = 40'h00_000f_4240;
	localparam pwc_time_type WIDTH_RST_NS = 40'h00_0001_86a0;
	localparam pwc_time_type EDGE_RST_NS = 40'h00_0000_0005;
	localparam logic [16:0] POINTS_RST = 17'h0_1000;

	// Minimum width bands, period thresholds in ns
	localparam pwc_time_type BAND1_NS = 40'h02_540b_e400;
	localparam pwc_time_type BAND2_NS = 40'h17_4876_e800;
	localparam pwc_time_type BAND3_NS = 40'he8_d4a5_1000;
	localparam pwc_time_type WMIN1_NS = 40'h00_0000_0014;
	localparam pwc_time_type WMIN2_NS = 40'h00_0000_00c8;
	localparam pwc_time_type WMIN3_NS = 40'h00_0000_07d0;
	localparam pwc_time_type WMIN4_NS = 40'h00_0000_4e20;

	// Edge factor 1.6 as 16/10, duty edge factor 160 in hundredths
	localparam logic [4:0] EDGE_NUM = 5'h10;
	localparam logic [3:0] EDGE_DEN = 4'ha;
	localparam logic [15:0] DUTY_EDGE_K = 16'h3e80;

	// Modulating shape symmetry in percent
	localparam logic [6:0] SYM_HALF = 7'h32;
	localparam logic [6:0] SYM_FULL = 7'h64;
	localparam logic [6:0] SYM_NONE = 7'h00;

	// Arbitrary shape reduced to 4K points
	localparam logic [16:0] PTS_ROUND = 17'h0_0fff;
	localparam int PTS_SHIFT = 12;
	localparam int EXT_SHIFT = 15;

endpackage

// ### dv/pulse_width_modulation_control_bench.sv
`timescale 1ns/1ps

module pulse_width_modulation_control_bench;
	typedef struct packed {
		logic wr;
		logic rd;
		logic [7:0] a;
		logic [31:0] d;
		logic [31:0] e;
	} pwc_row_type;

	logic clock_i = 1'b0;
	logic rst_b_i = 1'b0;
	logic hsel_i = 1'b0;
	logic [31:0] haddr_i = 32'h0;
	logic [1:0] htrans_i = 2'h0;
	logic hwrite_i = 1'b0;
	logic [31:0] hwdata_i = 32'h0;
	logic signed [15:0] ext_level_i = 16'h0000;
	logic [31:0] hrdata_o;
	logic hreadyout_o;
	logic hresp_o;
	pwc_pkg::pwc_ctrl_type mod_ctrl_o;
	logic [2:0] shape_o;
	logic [6:0] shape_sym_o;
	logic [31:0] mod_freq_o;
	logic [4:0] decim_step_o;
	logic signed [40:0] eff_wdev_o;
	logic signed [14:0] eff_ddev_o;
	int n_errors = 0;
	int cmp_count = 0;
	logic [31:0] q;
	longint ew;

	// ----------------------------------------
	// Ordinary cases: write, then read back
	// ----------------------------------------
	localparam int NR = 34;
	localparam pwc_row_type ROWS [NR] = '{
		'{1'b0, 1'b1, pwc_pkg::CTRL_OFS, 32'h0, 32'h0},
		'{1'b0, 1'b1, pwc_pkg::SHAPE_OFS, 32'h0, 32'h0},
		'{1'b0, 1'b1, pwc_pkg::FREQ_OFS, 32'h0, 32'h2710},
		'{1'b0, 1'b1, pwc_pkg::WDEV_OFS, 32'h0, 32'h2710},
		'{1'b0, 1'b1, pwc_pkg::DDEV_OFS, 32'h0, 32'h64},
		'{1'b1, 1'b1, pwc_pkg::FREQ_OFS, 32'h2, 32'h2},
		'{1'b1, 1'b1, pwc_pkg::FREQ_OFS, 32'h1, 32'h2},
		'{1'b1, 1'b1, pwc_pkg::FREQ_OFS, 32'h1312d00, 32'h1312d00},
		'{1'b1, 1'b1, pwc_pkg::FREQ_OFS, 32'h1312d01, 32'h1312d00},
		'{1'b1, 1'b1, pwc_pkg::SHAPE_OFS, 32'h7, 32'h0},
		'{1'b1, 1'b1, pwc_pkg::WDEV_OFS, 32'hc350, 32'hc350},
		'{1'b1, 1'b1, pwc_pkg::WDEV_OFS, 32'h30d40, 32'h1868c},
		'{1'b1, 1'b1, pwc_pkg::DDEV_OFS, 32'h1f4, 32'h1f4},
		'{1'b0, 1'b1, pwc_pkg::WDEV_OFS, 32'h0, 32'hc350},
		'{1'b1, 1'b1, pwc_pkg::DDEV_OFS, 32'h7d0, 32'h3e8},
		'{1'b1, 1'b1, pwc_pkg::CTRL_OFS, 32'h4, 32'h4},
		'{1'b1, 1'b1, pwc_pkg::WDEV_OFS, 32'h4e20, 32'h4e20},
		'{1'b0, 1'b1, pwc_pkg::DDEV_OFS, 32'h0, 32'hc8},
		'{1'b1, 1'b1, pwc_pkg::CTRL_OFS, 32'h0, 32'h0},
		'{1'b1, 1'b1, pwc_pkg::EDGE_OFS, 32'h64, 32'h64},
		'{1'b1, 1'b1, pwc_pkg::WDEV_OFS, 32'h30d40, 32'h18600},
		'{1'b1, 1'b1, pwc_pkg::DDEV_OFS, 32'h1388, 32'h3e7},
		'{1'b1, 1'b1, pwc_pkg::EDGE_OFS, 32'h5, 32'h5},
		'{1'b1, 1'b0, pwc_pkg::HI_OFS, 32'h2, 32'h0},
		'{1'b1, 1'b1, pwc_pkg::PERIOD_OFS, 32'h540be400, 32'h540be400},
		'{1'b1, 1'b0, pwc_pkg::HI_OFS, 32'h0, 32'h0},
		'{1'b1, 1'b1, pwc_pkg::WDEV_OFS, 32'h30d40, 32'h1868c},
		'{1'b1, 1'b0, pwc_pkg::HI_OFS, 32'h2, 32'h0},
		'{1'b1, 1'b1, pwc_pkg::PERIOD_OFS, 32'h540be401, 32'h540be401},
		'{1'b0, 1'b1, pwc_pkg::WDEV_OFS, 32'h0, 32'h1868c},
		'{1'b1, 1'b0, pwc_pkg::HI_OFS, 32'h0, 32'h0},
		'{1'b1, 1'b1, pwc_pkg::WDEV_OFS, 32'h30d40, 32'h185d8},
		'{1'b1, 1'b1, 8'h2c, 32'h1234, 32'h0},
		'{1'b1, 1'b1, pwc_pkg::PERIOD_OFS, 32'h0, 32'h540be401}
	};
	localparam logic [6:0] SYM [7] = '{7'h32, 7'h32, 7'h64, 7'h00, 7'h32, 7'h32, 7'h32};

	pwc_top i_pwc_top (
		.clock_i(clock_i),
		.rst_b_i(rst_b_i),
		.hsel_i(hsel_i),
		.haddr_i(haddr_i),
		.htrans_i(htrans_i),
		.hwrite_i(hwrite_i),
		.hsize_i(3'h2),
		.hwdata_i(hwdata_i),
		.hready_i(hreadyout_o),
		.hrdata_o(hrdata_o),
		.hreadyout_o(hreadyout_o),
		.hresp_o(hresp_o),
		.ext_level_i(ext_level_i),
		.mod_ctrl_o(mod_ctrl_o),
		.shape_o(shape_o),
		.shape_sym_o(shape_sym_o),
		.mod_freq_o(mod_freq_o),
		.decim_step_o(decim_step_o),
		.eff_wdev_o(eff_wdev_o),
		.eff_ddev_o(eff_ddev_o)
	);

	// Free-running 125 MHz clock
	always #4 clock_i = ~clock_i;

	task automatic chk(input logic [63:0] got, input logic [63:0] exp);
		cmp_count++;
		if (got !== exp) begin
			n_errors++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	// One single AHB-Lite transfer; waits on hready, never on a fixed count
	task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d,
			output logic [31:0] r);
		int n;
		hsel_i <= 1'b1;
		htrans_i <= 2'h2;
		haddr_i <= {24'h0, a};
		hwrite_i <= wr;
		n = 0;
		do begin
			@(posedge clock_i);
			n++;
		end while (hreadyout_o !== 1'b1 && n < 50);
		htrans_i <= 2'h0;
		hwdata_i <= d;
		n = 0;
		do begin
			@(posedge clock_i);
			n++;
		end while (hreadyout_o !== 1'b1 && n < 50);
		r = hrdata_o;
		chk(64'(hresp_o), 64'h0);
	endtask

	task automatic summarize();
		$display("errors %0d comparisons %0d", n_errors, cmp_count);
		if (n_errors == 0 && cmp_count > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask

	// Watchdog, well beyond the few hundred cycles the tests need
	initial begin
		#160000;
		n_errors++;
		summarize();
	end

	initial begin
		repeat (4) @(posedge clock_i);
		rst_b_i <= 1'b1;
		for (int i = 0; i < NR; i++) begin
			if (ROWS[i].wr) xfer(1'b1, ROWS[i].a, ROWS[i].d, q);
			if (ROWS[i].rd) begin
				xfer(1'b0, ROWS[i].a, 32'h0, q);
				chk(64'(q), 64'(ROWS[i].e));
			end
		end
		rst_b_i <= 1'b0;
		repeat (4) @(posedge clock_i);
		chk(64'(mod_ctrl_o), 64'h0);
		rst_b_i <= 1'b1;
		repeat (2) @(posedge clock_i);
		chk(64'(mod_freq_o), 64'h2710);
		chk(64'(shape_o), 64'h0);
		xfer(1'b1, pwc_pkg::CTRL_OFS, 32'h1f8, q);
		xfer(1'b0, pwc_pkg::CTRL_OFS, 32'h0, q);
		chk(64'(q), 64'h1f8);
		xfer(1'b1, pwc_pkg::CTRL_OFS, 32'h1f9, q);
		xfer(1'b0, pwc_pkg::CTRL_OFS, 32'h0, q);
		chk(64'(q), 64'h9);
		chk(64'(mod_ctrl_o), 64'h9);
		xfer(1'b1, pwc_pkg::CTRL_OFS, 32'h1f1, q);
		xfer(1'b0, pwc_pkg::CTRL_OFS, 32'h0, q);
		chk(64'(q[0]), 64'h0);
		xfer(1'b1, pwc_pkg::CTRL_OFS, 32'hb, q);
		ext_level_i <= 16'h7fff;
		repeat (3) @(posedge clock_i);
		ew = (64'sh2710 * 64'sh7fff) >>> 15;
		chk(64'(eff_wdev_o), 64'(ew));
		chk(64'(eff_ddev_o), 64'h63);
		ext_level_i <= 16'h8000;
		repeat (3) @(posedge clock_i);
		ew = -64'sh2710;
		chk(64'(eff_wdev_o), 64'(ew));
		xfer(1'b1, pwc_pkg::CTRL_OFS, 32'h8, q);
		repeat (3) @(posedge clock_i);
		chk(64'(eff_wdev_o), 64'h0);
		// every shape code and its symmetry
		for (int s = 0; s < 7; s++) begin
			xfer(1'b1, pwc_pkg::SHAPE_OFS, 32'(s), q);
			repeat (2) @(posedge clock_i);
			chk(64'(shape_o), 64'(s));
			chk(64'(shape_sym_o), 64'(SYM[s]));
		end
		// decimation step down to 4K points
		xfer(1'b1, pwc_pkg::POINTS_OFS, 32'h1000, q);
		repeat (2) @(posedge clock_i);
		chk(64'(decim_step_o), 64'h1);
		xfer(1'b1, pwc_pkg::POINTS_OFS, 32'h1001, q);
		xfer(1'b0, pwc_pkg::STATUS_OFS, 32'h0, q);
		chk(64'(q[20:16]), 64'h2);
		xfer(1'b1, pwc_pkg::POINTS_OFS, 32'h10000, q);
		repeat (2) @(posedge clock_i);
		chk(64'(decim_step_o), 64'h10);
		summarize();
	end
endmodule
